// >>> hdl/hsp_pkg.sv
// Package: constants and types for the host serial port
//
// How it works
// - Port settings: rate up to 38.4K, sync/async timing, duplex, parity.
// - Terminal side: drives data, RTS, DTR; reads data, CTS, DSR, DCD, clocks.
// - In synchronous timing, bits are timed from modem transmit/receive clocks.
// - Synchronous timing still uses async character framing; no sync characters.
// - Binary protocol frames are accepted only when address matches switch address.
// - XOFF stops transmission within four further characters.
// - Binary protocol: XON is 11 hex, XOFF 13 hex, bit eight clear.
// - ASCII protocol: XON/XOFF are 7-bit 11/13 checked with configured parity.
// - XON/XOFF is honoured only when full duplex is selected.
// - Frame start while paused clears the pause and drops that frame.
// - The device never sends XOFF itself.
// - ASCII characters: one start, seven data, optional parity, one stop.
// - One switch enables parity, another picks even or odd.
// - A switch selects full or half duplex.
// - Binary protocol moves eight-bit bytes with no parity.
package hsp_pkg;

  // ********************************
  // Timing
  // ********************************
  localparam int CLK_HZ         = 125_000_000;
  localparam int BAUD_MAX       = 38_400;
  localparam int OVERSAMPLE     = 16;
  // Baud rates the 16x tick divisor is worked out from, index is the rate code 0..9
  localparam int RATE_TABLE [10] = '{110, 150, 300, 600, 1200, 2400,
                                     4800, 9600, 19200, BAUD_MAX};
  localparam int XOFF_LIMIT     = 4;

  // ********************************
  // Characters
  // ********************************
  localparam logic [7:0] XON_CODE    = 8'h11;
  localparam logic [7:0] XOFF_CODE   = 8'h13;
  localparam logic [7:0] START_ASCII = 8'h3A;
  localparam logic [7:0] START_BIN   = 8'h7E;
  localparam int         BITS_ASCII  = 7;
  localparam int         BITS_BIN    = 8;
  localparam int         FIFO_DEPTH  = 4;

  typedef struct packed {
    logic       binary_proto;
    logic       parity_en;
    logic       parity_odd;
    logic       full_duplex;
    logic       sync_timing;
    logic [3:0] rate;
    logic [4:0] address;
  } hsp_cfg_t;

  typedef struct packed {
    logic       parity_err;
    logic       frame_err;
    logic [7:0] data;
  } hsp_rx_t;

endpackage

// >>> hdl/hsp_fifo.sv
// Small valid/ready FIFO between user and transmitter
`timescale 1ns/10ps
`default_nettype none
module hsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;
  assign o_data  = mem[rd_ptr];

  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= AW'(wr_ptr + 1'b1);
      end
      if (pop) begin
        rd_ptr <= AW'(rd_ptr + 1'b1);
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdl/hsp_port.sv
// Host serial port: DTE-side UART with XON/XOFF pause and address filter
`timescale 1ns/10ps
`default_nettype none
module hsp_port (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire hsp_pkg::hsp_cfg_t i_cfg,
  input  wire logic       [7:0] i_tx_data,
  input  wire logic             i_tx_valid,
  output logic                  o_tx_ready,
  output hsp_pkg::hsp_rx_t      o_rx,
  output logic                  o_rx_valid,
  output logic                  o_frame_drop,
  output logic                  o_paused,
  output logic                  o_txd,
  output logic                  o_rts,
  output logic                  o_dtr,
  input  wire logic             i_rxd,
  input  wire logic             i_cts,
  input  wire logic             i_dsr,
  input  wire logic             i_dcd,
  input  wire logic             i_tx_clk,
  input  wire logic             i_rx_clk
);

  // ********************************
  // Pin synchronisers
  // ********************************
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;
  logic       tclk_last;
  logic       rclk_last;
  logic       rxd;
  logic       cts;
  logic       dsr;
  logic       dcd;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pin_meta  <= 6'h3F;
      pin_sync  <= 6'h3F;
      tclk_last <= 1'b1;
      rclk_last <= 1'b1;
    end else begin
      pin_meta  <= {i_rxd, i_cts, i_dsr, i_dcd, i_tx_clk, i_rx_clk};
      pin_sync  <= pin_meta;
      tclk_last <= pin_sync[1];
      rclk_last <= pin_sync[0];
    end
  end
  // Circuits are treated as active high after the receivers
  assign rxd = pin_sync[5];
  assign cts = pin_sync[4];
  assign dsr = pin_sync[3];
  assign dcd = pin_sync[2];

  // ********************************
  // Bit timing
  // ********************************
  // 110 baud needs a 17-bit divisor at this clock
  logic [16:0] div_cnt;
  logic [16:0] div_max;
  logic        tick16;
  logic        tx_bit_en;
  logic        rx_smp_en;
  logic [3:0]  tx_sub;
  logic        sync_tx_edge;
  logic        sync_rx_edge;

  always_comb begin
    div_max = 17'(hsp_pkg::CLK_HZ /
                  (hsp_pkg::OVERSAMPLE * hsp_pkg::RATE_TABLE[0]) - 1);
    for (int k = 0; k < 10; k++) begin
      if (i_cfg.rate == 4'(k)) begin
        div_max = 17'(hsp_pkg::CLK_HZ /
                      (hsp_pkg::OVERSAMPLE * hsp_pkg::RATE_TABLE[k]) - 1);
      end
    end
  end

  assign tick16 = (div_cnt == div_max);
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt <= '0;
      tx_sub  <= '0;
    end else begin
      div_cnt <= tick16 ? 17'h00000 : 17'(div_cnt + 1'b1);
      if (tick16) begin
        tx_sub <= 4'(tx_sub + 1'b1);
      end
    end
  end

  // Modem clocks: send on falling edge, sample on rising
  assign sync_tx_edge = tclk_last & ~pin_sync[1];
  assign sync_rx_edge = ~rclk_last & pin_sync[0];
  assign tx_bit_en = i_cfg.sync_timing ? sync_tx_edge
                                       : (tick16 && tx_sub == 4'hF);

  // ********************************
  // Transmitter
  // ********************************
  logic [7:0] fifo_data;
  logic       fifo_valid;
  logic       fifo_ready;
  logic       pause;
  logic       tx_busy;
  logic [10:0] tx_shift;
  logic [3:0]  tx_left;
  logic        tx_par;
  logic        tx_done;
  logic [3:0]  n_data;

  hsp_fifo #(
    .WIDTH (8),
    .DEPTH (hsp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_data  (i_tx_data),
    .i_valid (i_tx_valid),
    .o_ready (o_tx_ready),
    .o_data  (fifo_data),
    .o_valid (fifo_valid),
    .i_ready (fifo_ready)
  );

  // Seven data bits for ASCII, eight for binary; parity only in ASCII
  assign n_data = i_cfg.binary_proto ? 4'(hsp_pkg::BITS_BIN)
                                     : 4'(hsp_pkg::BITS_ASCII);
  assign tx_par = ^fifo_data[6:0] ^ i_cfg.parity_odd;

  // Pause holds the next character in the FIFO so nothing is lost
  assign fifo_ready = fifo_valid && !tx_busy && !pause && cts && tx_bit_en;
  assign tx_done    = tx_busy && tx_bit_en && tx_left == 4'h1;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tx_busy  <= 1'b0;
      tx_shift <= 11'h7FF;
      tx_left  <= '0;
    end else if (fifo_ready) begin
      tx_busy <= 1'b1;
      if (i_cfg.binary_proto) begin
        tx_shift <= {2'b11, fifo_data, 1'b0};
        tx_left  <= 4'hA;
      end else if (i_cfg.parity_en) begin
        tx_shift <= {2'b11, tx_par, fifo_data[6:0], 1'b0};
        tx_left  <= 4'hA;
      end else begin
        tx_shift <= {3'b111, fifo_data[6:0], 1'b0};
        tx_left  <= 4'h9;
      end
    end else if (tx_busy && tx_bit_en) begin
      tx_shift <= {1'b1, tx_shift[10:1]};
      tx_left  <= 4'(tx_left - 1'b1);
      if (tx_done) begin
        tx_busy <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_txd <= 1'b1;
      o_rts <= 1'b0;
      o_dtr <= 1'b0;
    end else begin
      o_txd <= tx_busy ? tx_shift[0] : 1'b1;
      o_dtr <= 1'b1;
      // Half duplex raises request to send only while there is data
      o_rts <= i_cfg.full_duplex | fifo_valid | tx_busy;
    end
  end

  // ********************************
  // Receiver (always async framing)
  // ********************************
  logic       rx_busy;
  logic [3:0] rx_phase;
  logic [3:0] rx_idx;
  logic [9:0] rx_bits;
  logic       rx_end;
  logic [3:0] rx_total;
  logic [7:0] rx_byte;
  logic       rx_perr;
  logic       rx_start;

  assign rx_smp_en = i_cfg.sync_timing ? sync_rx_edge
                                       : (tick16 && rx_phase == 4'h7);
  assign rx_total  = 4'(n_data + 4'(i_cfg.parity_en & ~i_cfg.binary_proto)
                     + 4'h1);
  assign rx_end    = rx_busy && rx_smp_en && rx_idx == rx_total;
  assign rx_start  = !rx_busy && !rxd && dsr;

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rx_busy  <= 1'b0;
      rx_phase <= '0;
      rx_idx   <= '0;
      rx_bits  <= '0;
    end else if (rx_start) begin
      // Start bit found: character framing even in sync timing
      rx_busy  <= 1'b1;
      rx_phase <= '0;
      rx_idx   <= '0;
    end else if (rx_busy) begin
      if (tick16) begin
        rx_phase <= 4'(rx_phase + 1'b1);
      end
      if (rx_smp_en) begin
        rx_bits <= {rxd, rx_bits[9:1]};
        rx_idx  <= 4'(rx_idx + 1'b1);
        if (rx_idx == rx_total) begin
          rx_busy <= 1'b0;
        end
      end
    end
  end

  // Right-align the captured bits: start, data, parity; the stop bit is read from rxd
  always_comb begin
    logic [9:0] al;
    al      = rx_bits >> (4'hA - rx_total);
    rx_byte = i_cfg.binary_proto ? al[8:1] : {1'b0, al[7:1]};
    rx_perr = i_cfg.parity_en && !i_cfg.binary_proto &&
              ((^al[8:1]) != i_cfg.parity_odd);
  end

  // ********************************
  // Flow control and frame filter
  // ********************************
  logic got_xon;
  logic got_xoff;
  logic got_sof;
  logic discard;
  logic addr_wait;
  logic addr_ok;

  assign got_xon  = rx_end && !rx_perr && rx_byte == hsp_pkg::XON_CODE;
  assign got_xoff = rx_end && !rx_perr && rx_byte == hsp_pkg::XOFF_CODE;
  assign got_sof  = rx_end && rx_byte == (i_cfg.binary_proto ?
                    hsp_pkg::START_BIN : hsp_pkg::START_ASCII);
  assign addr_ok  = rx_byte[4:0] == i_cfg.address && rx_byte[7:5] == 3'h0;

  // Current character finishes, so the stop lands well inside four
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pause <= 1'b0;
    end else if (!i_cfg.full_duplex) begin
      pause <= 1'b0;
    end else if (got_sof && pause) begin
      pause <= 1'b0;
    end else if (got_xoff) begin
      pause <= 1'b1;
    end else if (got_xon) begin
      pause <= 1'b0;
    end
  end
  // Device never emits XOFF: transmit path only carries user data

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      discard   <= 1'b0;
      addr_wait <= 1'b0;
    end else if (got_sof) begin
      discard   <= pause && i_cfg.full_duplex;
      addr_wait <= i_cfg.binary_proto;
    end else if (rx_end && addr_wait) begin
      addr_wait <= 1'b0;
      if (!addr_ok) begin
        discard <= 1'b1;
      end
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rx         <= '0;
      o_rx_valid   <= 1'b0;
      o_frame_drop <= 1'b0;
      o_paused     <= 1'b0;
    end else begin
      o_paused     <= pause;
      o_frame_drop <= got_sof && pause && i_cfg.full_duplex;
      o_rx_valid   <= rx_end && dcd && !got_sof && !discard && !addr_wait
                      && !(i_cfg.full_duplex && (got_xon || got_xoff));
      if (rx_end) begin
        o_rx.data       <= rx_byte;
        o_rx.parity_err <= rx_perr;
        o_rx.frame_err  <= !rxd;
      end
    end
  end

endmodule
`default_nettype wire

// >>> test/hsp_port_sva.sv
// Concurrent checks on the host serial port's pins
`timescale 1ns/10ps
`default_nettype none
module hsp_port_sva (
  input wire logic              i_clock,
  input wire logic              i_rst_b,
  input wire hsp_pkg::hsp_cfg_t i_cfg,
  input wire logic              o_rx_valid,
  input wire logic              o_frame_drop,
  input wire logic              o_paused,
  input wire logic              o_txd,
  input wire logic              o_rts,
  input wire logic              o_dtr
);
  // Saturates, only passing the bound matters
  logic [9:0] paused_cycles;
  always_ff @(posedge i_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      paused_cycles <= 10'h000;
    end else if (!o_paused) begin
      paused_cycles <= 10'h000;
    end else if (paused_cycles != 10'h3FF) begin
      paused_cycles <= paused_cycles + 10'h001;
    end
  end
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  AST_DTR_UP: assert property ($past(i_rst_b) |-> o_dtr)
    else $error("terminal ready low after reset");
  AST_IDLE_NO_RTS: assert property (!o_rts |-> o_txd)
    else $error("data line active without request to send");
  AST_RTS_FULL: assert property (
    $past(i_rst_b) && $past(i_cfg.full_duplex) |-> o_rts)
    else $error("request to send low in full duplex");
  AST_PAUSE_FULL: assert property (
    $rose(o_paused) |-> $past(i_cfg.full_duplex))
    else $error("paused while half duplex");
  AST_XOFF_STOP: assert property (
    paused_cycles > 10'h190 && i_cfg.sync_timing |-> o_txd)
    else $error("still sending long after pause");
  AST_DROP_PAUSED: assert property (
    o_frame_drop |-> $past(o_paused) || $past(o_paused, 2))
    else $error("frame dropped while not paused");
  AST_DROP_CLEARS: assert property (o_frame_drop |-> ##[0:2] !o_paused)
    else $error("pause not cleared by frame start");
  AST_RX_PULSE: assert property (o_rx_valid |=> !o_rx_valid)
    else $error("receive strobe longer than one cycle");
  // Assumes the modem bit clock is no faster than 8 system clocks
  AST_SYNC_BIT: assert property (
    $changed(o_txd) && i_cfg.sync_timing |=> $stable(o_txd) [*4])
    else $error("bit shorter than the modem clock allows");
endmodule
bind hsp_port hsp_port_sva chk (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_cfg(i_cfg), .o_rx_valid(o_rx_valid), .o_frame_drop(o_frame_drop),
  .o_paused(o_paused), .o_txd(o_txd), .o_rts(o_rts), .o_dtr(o_dtr));
`default_nettype wire

// >>> test/hsp_host_model.sv
// Host computer partner: modem clocks, serial sender and receiver
`timescale 1ns/10ps
`default_nettype none
module hsp_host_model (
  input  wire logic  i_clock,
  input  wire logic  i_long,
  input  wire logic  i_txd,
  output logic       o_rxd,
  output logic       o_tx_clk,
  output logic       o_rx_clk,
  output logic [7:0] o_byte,
  output logic       o_got
);
  // Modem bit clocks run free at 64 ns, out of phase with the system
  initial begin
    o_tx_clk = 1'b0;
    #3;
    forever #32 o_tx_clk = ~o_tx_clk;
  end
  initial begin
    o_rx_clk = 1'b0;
    #19;
    forever #32 o_rx_clk = ~o_rx_clk;
  end
  // Start, bits LSB first, stop; changes on the falling edge
  task automatic send(input logic [9:0] frame);
    for (int i = 0; i < 10; i++) begin
      @(negedge o_rx_clk);
      o_rxd = frame[i];
    end
  endtask
  // No flow control of its own on this side
  initial begin
    o_rxd = 1'b1;
    o_got = 1'b0;
    o_byte = 8'h00;
    forever begin
      @(posedge o_tx_clk);
      if (i_txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          @(posedge o_tx_clk);
          o_byte[i] = i_txd;
        end
        if (i_long) @(posedge o_tx_clk);
        @(posedge i_clock);
        o_got <= 1'b1;
        @(posedge i_clock);
        o_got <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// >>> test/hsp_port_tb.sv
// Self-checking testbench for the host serial port
`timescale 1ns/10ps
`default_nettype none
module hsp_port_tb;
  logic              i_clock, i_rst_b, tx_valid, tx_ready, rx_valid;
  logic              frame_drop, paused, txd, rts, dtr, rxd, tx_clk;
  logic              rx_clk, got;
  logic        [7:0] tx_data, got_byte;
  hsp_pkg::hsp_cfg_t cfg;
  hsp_pkg::hsp_rx_t  rx;
  logic        [8:0] txq[$];
  logic        [9:0] rxq[$];
  logic       [31:0] seed = 32'h741DBE67;
  int                n_fail = 0, comparisons = 0, drops = 0;
  hsp_port dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_cfg(cfg),
    .i_tx_data(tx_data), .i_tx_valid(tx_valid), .o_tx_ready(tx_ready),
    .o_rx(rx), .o_rx_valid(rx_valid), .o_frame_drop(frame_drop),
    .o_paused(paused), .o_txd(txd), .o_rts(rts), .o_dtr(dtr), .i_rxd(rxd),
    .i_cts(1'b1), .i_dsr(1'b1), .i_dcd(1'b1), .i_tx_clk(tx_clk),
    .i_rx_clk(rx_clk));
  hsp_host_model host (.i_clock(i_clock), .i_txd(txd), .o_rxd(rxd),
    .i_long(cfg.binary_proto | cfg.parity_en), .o_tx_clk(tx_clk),
    .o_rx_clk(rx_clk), .o_byte(got_byte), .o_got(got));
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // Bits as they cross the wire after the start bit
  function automatic logic [8:0] on_wire(input logic [7:0] d);
    if (cfg.binary_proto) return {1'b0, d};
    if (cfg.parity_en) return {1'b0, ^d[6:0] ^ cfg.parity_odd, d[6:0]};
    return {2'b01, d[6:0]};
  endfunction
  task automatic give_verdict(input logic hung);
    if (hung) n_fail++;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [9:0] got_v, input logic [9:0] exp_v);
    comparisons++;
    if (got_v !== exp_v) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  // Valid stays up between back-to-back bytes
  task automatic put(input logic [7:0] d);
    int   k;
    logic ok;
    k = 0;
    tx_data <= d;
    tx_valid <= 1'b1;
    txq.push_back(on_wire(d));
    do begin
      #1 ok = tx_ready;
      @(posedge i_clock);
      k++;
    end while (ok !== 1'b1 && k < 5000);
    if (ok !== 1'b1) give_verdict(1'b1);
  endtask
  task automatic hear(input logic [7:0] d, input logic bad, input logic kept);
    logic [8:0] w;
    w = on_wire(d) ^ {1'b0, bad, 7'h00};
    // Frame error clear: the model always sends a good stop bit
    if (kept) rxq.push_back({1'b0, bad, cfg.binary_proto & d[7], d[6:0]});
    host.send({1'b1, w[7:0], 1'b0});
  endtask
  task automatic drain();
    int k;
    k = 0;
    while ((txq.size() != 0 || rxq.size() != 0) && k < 20000) begin
      @(posedge i_clock);
      k++;
    end
    if (txq.size() != 0 || rxq.size() != 0) give_verdict(1'b1);
    repeat (40) @(posedge i_clock);
  endtask
  // ****
  // Result watcher
  // ****
  always @(posedge i_clock) begin
    if (got === 1'b1) cmp({2'b00, got_byte},
      {1'b0, txq.size() ? txq.pop_front() : 9'h1FF});
    if (rx_valid === 1'b1) cmp(
      {rx.frame_err, rx.parity_err, rx.data},
      rxq.size() ? rxq.pop_front() : 10'h3FF);
    if (frame_drop === 1'b1) drops++;
  end
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  // ****
  // Scenarios
  // ****
  initial begin
    i_rst_b = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    cfg = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h9, 5'h05};
    repeat (4) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (int m = 0; m < 4; m++) begin
      cfg.binary_proto <= (m == 3);
      cfg.parity_en <= (m == 1 || m == 2);
      cfg.parity_odd <= (m == 2);
      @(posedge i_clock);
      repeat (5) put(xs());
      tx_valid <= 1'b0;
      if (m < 3) begin
        hear(xs() | 8'h40, 1'b0, 1'b1);
        hear(xs() | 8'h40, cfg.parity_en, 1'b1);
      end
      drain();
    end
    cfg.binary_proto <= 1'b0;
    @(posedge i_clock);
    for (int r = 0; r < 2; r++) begin
      repeat (4) put(xs());
      tx_valid <= 1'b0;
      hear(hsp_pkg::XOFF_CODE, 1'b0, 1'b0);
      repeat (20) @(posedge i_clock);
      cmp({9'h000, paused}, 10'h001);
      repeat (500) @(posedge i_clock);
      cmp({9'h000, txq.size() != 0}, 10'h001);
      hear(r ? hsp_pkg::START_ASCII : hsp_pkg::XON_CODE, 1'b0, 1'b0);
      repeat (20) @(posedge i_clock);
      cmp({9'h000, paused}, 10'h000);
      drain();
    end
    cmp(10'(drops), 10'h001);
    // Multidrop modems would run half duplex; here flow control is off
    cfg.full_duplex <= 1'b0;
    @(posedge i_clock);
    // New frame start ends the discard left by the pause recovery
    hear(hsp_pkg::START_ASCII, 1'b0, 1'b0);
    hear(hsp_pkg::XOFF_CODE, 1'b0, 1'b1);
    repeat (20) @(posedge i_clock);
    cmp({9'h000, paused}, 10'h000);
    repeat (2) put(xs());
    tx_valid <= 1'b0;
    drain();
    cfg <= '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 4'h9, 5'h05};
    @(posedge i_clock);
    hear(hsp_pkg::START_BIN, 1'b0, 1'b0);
    hear(8'h06, 1'b0, 1'b0);
    hear(8'h5A, 1'b0, 1'b0);
    hear(hsp_pkg::START_BIN, 1'b0, 1'b0);
    hear(8'h05, 1'b0, 1'b0);
    hear(8'hDA, 1'b0, 1'b1);
    drain();
    give_verdict(1'b0);
  end
endmodule
`default_nettype wire
